// ---- rtl/vector_pkg.sv ----
package vector_pkg;

  localparam int XLEN   = 64;
  localparam int APB_AW = 8;

  // Register byte addresses
  localparam logic [APB_AW-1:0] REG_BASE_LO = 8'h00;
  localparam logic [APB_AW-1:0] REG_BASE_HI = 8'h04;
  localparam logic [APB_AW-1:0] REG_CTRL    = 8'h08;
  localparam logic [APB_AW-1:0] REG_STATUS  = 8'h0C;
  localparam logic [APB_AW-1:0] REG_EXC_LO  = 8'h10;
  localparam logic [APB_AW-1:0] REG_EXC_HI  = 8'h14;
  localparam logic [APB_AW-1:0] REG_FCR_LO  = 8'h18;
  localparam logic [APB_AW-1:0] REG_FCR_HI  = 8'h1C;

  // Field layout and reset values
  localparam int          BASE_LSB      = 15;
  localparam logic [31:0] BASE_LO_MASK  = 32'hFFFF8000;
  localparam logic [31:0] WORD_RESET    = 32'h00000000;
  localparam logic [63:0] DWORD_RESET   = 64'h0000000000000000;
  localparam int          CTRL_HWE_BIT  = 0;
  localparam logic        HWE_RESET     = 1'b0;
  localparam int          ST_BUBBLE_BIT = 0;
  localparam int          ST_ILL_BIT    = 1;
  localparam int          ST_FCW_BIT    = 2;
  localparam int          ST_CAUSE_LSB  = 4;
  localparam int          ST_CAUSE_MSB  = 7;

  // Call function field decode
  localparam logic [1:0] MODE_KERNEL   = 2'h0;
  localparam logic [7:0] FUNC_PRIV_MAX = 8'h3F;
  localparam logic [7:0] FUNC_ILL_LO   = 8'h40;
  localparam logic [7:0] FUNC_ILL_HI   = 8'h7F;
  localparam logic [7:0] FUNC_MAX      = 8'hBF;
  localparam logic [1:0] CALL_PREFIX   = 2'h1;

  // Opcodes checked at issue
  localparam logic [5:0] OPC_RSV_LO = 6'h01;
  localparam logic [5:0] OPC_RSV_HI = 6'h07;
  localparam logic [5:0] OPC_HW_19  = 6'h19;
  localparam logic [5:0] OPC_HW_1B  = 6'h1B;
  localparam logic [5:0] OPC_HW_1D  = 6'h1D;
  localparam logic [5:0] OPC_HW_1E  = 6'h1E;
  localparam logic [5:0] OPC_HW_1F  = 6'h1F;

  // Entry offsets from the vector base
  localparam logic [14:0] OFF_PTE_MISS_3   = 15'h0100;
  localparam logic [14:0] OFF_PTE_MISS_4   = 15'h0180;
  localparam logic [14:0] OFF_FLOAT_DIS    = 15'h0200;
  localparam logic [14:0] OFF_MISALIGNED   = 15'h0280;
  localparam logic [14:0] OFF_DATA_MISS    = 15'h0300;
  localparam logic [14:0] OFF_DATA_FAULT   = 15'h0380;
  localparam logic [14:0] OFF_ILLEGAL_OPC  = 15'h0400;
  localparam logic [14:0] OFF_INSTR_VIOL   = 15'h0480;
  localparam logic [14:0] OFF_MACHINE_CHK  = 15'h0500;
  localparam logic [14:0] OFF_INSTR_MISS   = 15'h0580;
  localparam logic [14:0] OFF_ARITHMETIC   = 15'h0600;
  localparam logic [14:0] OFF_INTERRUPT    = 15'h0680;
  localparam logic [14:0] OFF_FLOAT_CTRL_W = 15'h0700;
  localparam logic [14:0] OFF_RESTART_WAKE = 15'h0780;

  typedef enum logic [3:0] {
    CAUSE_NONE             = 4'h0,
    CAUSE_PTE_MISS_3       = 4'h1,
    CAUSE_PTE_MISS_4       = 4'h2,
    CAUSE_FLOAT_DISABLED   = 4'h3,
    CAUSE_MISALIGNED       = 4'h4,
    CAUSE_DATA_MISS        = 4'h5,
    CAUSE_DATA_FAULT       = 4'h6,
    CAUSE_ILLEGAL_OPCODE   = 4'h7,
    CAUSE_INSTR_VIOLATION  = 4'h8,
    CAUSE_MACHINE_CHECK    = 4'h9,
    CAUSE_INSTR_MISS       = 4'hA,
    CAUSE_ARITHMETIC       = 4'hB,
    CAUSE_INTERRUPT        = 4'hC,
    CAUSE_FLOAT_CTRL_WRITE = 4'hD,
    CAUSE_RESTART_WAKE     = 4'hE
  } cause_t;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_BUBBLE = 1'b1
  } call_state_t;

  typedef struct packed {
    logic            valid;
    logic [7:0]      func;
    logic [XLEN-1:0] next_pc;
  } call_req_t;

  typedef struct packed {
    logic            valid;
    cause_t          cause;
    logic [XLEN-1:0] ret_pc;
  } exc_req_t;

  typedef struct packed {
    logic            valid;
    logic [5:0]      opcode;
    logic            ext_precision;
    logic            unimpl_func;
    logic [XLEN-1:0] pc;
  } issue_chk_t;

  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] data;
    logic [XLEN-1:0] pc;
  } fcw_issue_t;

  typedef struct packed {
    logic            valid;
    logic            abort;
    logic [XLEN-1:0] target;
  } redirect_t;

  typedef struct packed {
    logic            valid;
    logic [XLEN-1:0] data;
  } word_push_t;

  function automatic logic [14:0] cause_offset(input cause_t c);
    logic [14:0] off;
    off = OFF_RESTART_WAKE;
    unique case (c)
      CAUSE_PTE_MISS_3:       off = OFF_PTE_MISS_3;
      CAUSE_PTE_MISS_4:       off = OFF_PTE_MISS_4;
      CAUSE_FLOAT_DISABLED:   off = OFF_FLOAT_DIS;
      CAUSE_MISALIGNED:       off = OFF_MISALIGNED;
      CAUSE_DATA_MISS:        off = OFF_DATA_MISS;
      CAUSE_DATA_FAULT:       off = OFF_DATA_FAULT;
      CAUSE_ILLEGAL_OPCODE:   off = OFF_ILLEGAL_OPC;
      CAUSE_INSTR_VIOLATION:  off = OFF_INSTR_VIOL;
      CAUSE_MACHINE_CHECK:    off = OFF_MACHINE_CHK;
      CAUSE_INSTR_MISS:       off = OFF_INSTR_MISS;
      CAUSE_ARITHMETIC:       off = OFF_ARITHMETIC;
      CAUSE_INTERRUPT:        off = OFF_INTERRUPT;
      CAUSE_FLOAT_CTRL_WRITE: off = OFF_FLOAT_CTRL_W;
      default:                off = OFF_RESTART_WAKE;
    endcase
    return off;
  endfunction : cause_offset

endpackage : vector_pkg

// ---- rtl/call_entry_decode.sv ----
`timescale 1ns/1ps
module call_entry_decode
(
  input  wire logic [7:0]                  func,
  input  wire logic [1:0]                  current_mode_field,
  input  wire logic [vector_pkg::XLEN-1:0] privileged_vector_base,
  output logic                             illegal,
  output logic [vector_pkg::XLEN-1:0]      target
);

  logic [vector_pkg::XLEN-1:0] legal_target;

  // Illegal function codes and mode check
  always_comb
  begin
    illegal = ((func >= vector_pkg::FUNC_ILL_LO) && (func <= vector_pkg::FUNC_ILL_HI))
           || (func > vector_pkg::FUNC_MAX)
           || ((func <= vector_pkg::FUNC_PRIV_MAX)
               && (current_mode_field != vector_pkg::MODE_KERNEL));
  end

  // Entry point of a legal call
  always_comb
  begin
    legal_target = {privileged_vector_base[vector_pkg::XLEN-1:vector_pkg::BASE_LSB],
                    vector_pkg::CALL_PREFIX, func[7], func[5:0], 5'h00, 1'b1};
  end

  always_comb
  begin
    target = illegal
           ? {privileged_vector_base[vector_pkg::XLEN-1:vector_pkg::BASE_LSB],
              vector_pkg::OFF_ILLEGAL_OPC[14:1], 1'b1}
           : legal_target;
  end

endmodule : call_entry_decode

// ---- rtl/privileged_entry_vector_logic.sv ----
`timescale 1ns/1ps
module privileged_entry_vector_logic
(
  input  wire logic                                     clock,
  input  wire logic                                     rst_n,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [vector_pkg::APB_AW-1:0]            paddr,
  input  wire logic [31:0]                              pwdata,
  input  wire logic [3:0]                               pstrb,
  output logic [31:0]                                   prdata,
  output logic                                          pready,
  output logic                                          pslverr,
  input  wire vector_pkg::call_req_t                    call_req,
  input  wire vector_pkg::exc_req_t                     exc_req,
  input  wire vector_pkg::issue_chk_t                   issue_chk,
  input  wire vector_pkg::fcw_issue_t                   fcw_issue,
  input  wire logic                                     fcw_retire,
  input  wire logic [1:0]                               current_mode_field,
  input  wire logic                                     privileged_code_mode,
  output logic                                          fetch_idle,
  output vector_pkg::redirect_t                         redirect,
  output vector_pkg::word_push_t                        link_write,
  output vector_pkg::word_push_t                        ras_push,
  output logic [vector_pkg::XLEN-1:0]                   exc_return_addr,
  output logic [vector_pkg::XLEN-1:0]                   fcr_first,
  output logic [vector_pkg::XLEN-1:0]                   fcr_second
);

  logic [31:0]                 base_lo_q;
  logic [31:0]                 base_hi_q;
  logic                        hwe_q;
  logic [vector_pkg::XLEN-1:0] privileged_vector_base;
  vector_pkg::call_state_t     state_q;
  vector_pkg::call_state_t     state_d;
  logic [vector_pkg::XLEN-1:0] call_target_q;
  logic                        call_ill_q;
  logic                        call_ill;
  logic [vector_pkg::XLEN-1:0] call_target;
  logic                        call_take;
  logic                        opc_illegal;
  logic                        fcw_pend_q;
  logic [vector_pkg::XLEN-1:0] fcw_pc_q;
  logic                        exc_take;
  vector_pkg::cause_t          exc_cause;
  logic [14:0]                 exc_off;
  logic [vector_pkg::XLEN-1:0] exc_pc;
  vector_pkg::cause_t          last_cause_q;
  logic                        apb_wr;
  logic                        apb_rd;
  logic                        addr_hit;
  logic [31:0]                 rd_word;

  assign privileged_vector_base = {base_hi_q, base_lo_q};

  // Register bus slave, zero wait states
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      base_lo_q <= vector_pkg::WORD_RESET;
      base_hi_q <= vector_pkg::WORD_RESET;
      hwe_q     <= vector_pkg::HWE_RESET;
    end
    else if (apb_wr)
    begin
      if (paddr == vector_pkg::REG_BASE_LO)
      begin
        base_lo_q <= lane_merge(base_lo_q, pwdata, pstrb) & vector_pkg::BASE_LO_MASK;
      end
      if (paddr == vector_pkg::REG_BASE_HI)
      begin
        base_hi_q <= lane_merge(base_hi_q, pwdata, pstrb);
      end
      if ((paddr == vector_pkg::REG_CTRL) && pstrb[0])
      begin
        hwe_q <= pwdata[vector_pkg::CTRL_HWE_BIT];
      end
    end
  end

  always_comb
  begin
    addr_hit = 1'b1;
    rd_word  = vector_pkg::WORD_RESET;
    unique case (paddr)
      vector_pkg::REG_BASE_LO: rd_word = base_lo_q;
      vector_pkg::REG_BASE_HI: rd_word = base_hi_q;
      vector_pkg::REG_CTRL:    rd_word[vector_pkg::CTRL_HWE_BIT] = hwe_q;
      vector_pkg::REG_STATUS:
      begin
        rd_word[vector_pkg::ST_BUBBLE_BIT] = (state_q == vector_pkg::ST_BUBBLE);
        rd_word[vector_pkg::ST_ILL_BIT]    = call_ill_q;
        rd_word[vector_pkg::ST_FCW_BIT]    = fcw_pend_q;
        rd_word[vector_pkg::ST_CAUSE_MSB:vector_pkg::ST_CAUSE_LSB] = last_cause_q;
      end
      vector_pkg::REG_EXC_LO:  rd_word = exc_return_addr[31:0];
      vector_pkg::REG_EXC_HI:  rd_word = exc_return_addr[63:32];
      vector_pkg::REG_FCR_LO:  rd_word = fcr_second[31:0];
      vector_pkg::REG_FCR_HI:  rd_word = fcr_second[63:32];
      default:                 addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      prdata <= vector_pkg::WORD_RESET;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= rd_word;
    end
  end

  // Call function decode
  call_entry_decode u_call_decode
  (
    .func                   (call_req.func),
    .current_mode_field     (current_mode_field),
    .privileged_vector_base (privileged_vector_base),
    .illegal                (call_ill),
    .target                 (call_target)
  );

  // Opcode legality at issue
  always_comb
  begin
    opc_illegal = issue_chk.valid &&
      (((issue_chk.opcode >= vector_pkg::OPC_RSV_LO) && (issue_chk.opcode <= vector_pkg::OPC_RSV_HI))
       || (((issue_chk.opcode == vector_pkg::OPC_HW_19) || (issue_chk.opcode == vector_pkg::OPC_HW_1B)
           || (issue_chk.opcode == vector_pkg::OPC_HW_1D) || (issue_chk.opcode == vector_pkg::OPC_HW_1E)
           || (issue_chk.opcode == vector_pkg::OPC_HW_1F))
           && (!privileged_code_mode || !hwe_q))
       || issue_chk.ext_precision || issue_chk.unimpl_func);
  end

  // Exception source selection: external, then opcode check, then float-control trap
  always_comb
  begin
    exc_take  = 1'b1;
    exc_cause = exc_req.cause;
    exc_pc    = exc_req.ret_pc;
    if (exc_req.valid && (exc_req.cause != vector_pkg::CAUSE_NONE))
    begin
      exc_cause = exc_req.cause;
    end
    else if (opc_illegal)
    begin
      exc_cause = vector_pkg::CAUSE_ILLEGAL_OPCODE;
      exc_pc    = issue_chk.pc;
    end
    else if (fcw_pend_q)
    begin
      exc_cause = vector_pkg::CAUSE_FLOAT_CTRL_WRITE;
      exc_pc    = fcw_pc_q;
    end
    else
    begin
      exc_take  = 1'b0;
    end
  end

  assign call_take = call_req.valid && (state_q == vector_pkg::ST_IDLE) && !exc_take;

  // Entry offset of the selected cause
  assign exc_off = vector_pkg::cause_offset(exc_cause);

  // Call sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      vector_pkg::ST_IDLE:   state_d = call_take ? vector_pkg::ST_BUBBLE : vector_pkg::ST_IDLE;
      vector_pkg::ST_BUBBLE: state_d = vector_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_q       <= vector_pkg::ST_IDLE;
      call_target_q <= vector_pkg::DWORD_RESET;
      call_ill_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (call_take)
      begin
        call_target_q <= call_target;
        call_ill_q    <= call_ill;
      end
    end
  end

  assign fetch_idle = (state_q == vector_pkg::ST_BUBBLE);

  // Fetch redirect, linkage write and return stack push
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      redirect     <= '0;
      link_write   <= '0;
      ras_push     <= '0;
      last_cause_q <= vector_pkg::CAUSE_NONE;
    end
    else
    begin
      redirect   <= '0;
      link_write <= '0;
      ras_push   <= '0;
      if (exc_take)
      begin
        redirect.valid  <= 1'b1;
        redirect.abort  <= 1'b1;
        redirect.target <= {privileged_vector_base[vector_pkg::XLEN-1:vector_pkg::BASE_LSB],
                            exc_off[14:1], 1'b1};
        ras_push.valid  <= 1'b1;
        ras_push.data   <= exc_pc;
        last_cause_q    <= exc_cause;
      end
      else if (state_q == vector_pkg::ST_BUBBLE)
      begin
        redirect.valid  <= 1'b1;
        redirect.target <= call_target_q;
      end
      if (call_take)
      begin
        link_write.valid <= 1'b1;
        link_write.data  <= {call_req.next_pc[vector_pkg::XLEN-1:1], privileged_code_mode};
        ras_push.valid   <= 1'b1;
        ras_push.data    <= call_req.next_pc;
      end
    end
  end

  // Exception return address
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      exc_return_addr <= vector_pkg::DWORD_RESET;
    end
    else if (exc_take)
    begin
      exc_return_addr <= exc_pc;
    end
  end

  // Float-control write latches and pending trap
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      fcr_first  <= vector_pkg::DWORD_RESET;
      fcr_second <= vector_pkg::DWORD_RESET;
      fcw_pend_q <= 1'b0;
      fcw_pc_q   <= vector_pkg::DWORD_RESET;
    end
    else
    begin
      if (fcw_issue.valid)
      begin
        fcr_first  <= fcw_issue.data;
        fcw_pc_q   <= fcw_issue.pc;
        fcw_pend_q <= 1'b1;
      end
      else if (exc_take && (exc_cause == vector_pkg::CAUSE_FLOAT_CTRL_WRITE))
      begin
        fcw_pend_q <= 1'b0;
      end
      if (fcw_retire)
      begin
        fcr_second <= fcr_first;
      end
    end
  end

  sequence s_call_taken;
    call_take;
  endsequence

  sequence s_bubble_then_jump;
    fetch_idle ##1 (redirect.valid && !redirect.abort);
  endsequence

  sequence s_fcw_trap_due;
    fcw_issue.valid ##1 (!exc_req.valid && !opc_illegal);
  endsequence

  a_call_bubble_jump: assert property (@(posedge clock) disable iff (!rst_n)
    s_call_taken ##1 !exc_take |-> s_bubble_then_jump)
    else $error("call did not idle one cycle then jump");

  a_call_no_abort: assert property (@(posedge clock) disable iff (!rst_n)
    $past(fetch_idle) && !$past(exc_take) |-> redirect.valid && !redirect.abort
      && redirect.target == $past(call_target_q))
    else $error("call redirect wrong or aborted");

  a_link_value: assert property (@(posedge clock) disable iff (!rst_n)
    call_take |=> link_write.valid
      && link_write.data[63:1] == $past(call_req.next_pc[63:1]))
    else $error("linkage value wrong");

  a_link_mode_bit: assert property (@(posedge clock) disable iff (!rst_n)
    call_take |=> link_write.data[0] == $past(privileged_code_mode))
    else $error("linkage mode bit wrong");

  a_call_ras_push: assert property (@(posedge clock) disable iff (!rst_n)
    call_take |=> ras_push.valid && ras_push.data == $past(call_req.next_pc))
    else $error("call return address not pushed");

  a_call_legal_tgt: assert property (@(posedge clock) disable iff (!rst_n)
    call_take && !call_ill |=> call_target_q[14:0] ==
      {2'h1, $past(call_req.func[7]), $past(call_req.func[5:0]), 6'h01})
    else $error("legal call target wrong");

  a_call_illegal: assert property (@(posedge clock) disable iff (!rst_n)
    call_take && (call_req.func > 8'hBF || (call_req.func[7:6] == 2'h1))
      |=> call_target_q[14:0] == 15'h0401)
    else $error("illegal call not diverted");

  a_call_user_mode: assert property (@(posedge clock) disable iff (!rst_n)
    call_take && call_req.func <= 8'h3F && current_mode_field != 2'h0 |=> call_ill_q)
    else $error("privileged call in user mode not diverted");

  a_exc_ret_addr: assert property (@(posedge clock) disable iff (!rst_n)
    exc_take |=> exc_return_addr == $past(exc_pc) && ras_push.data == $past(exc_pc))
    else $error("exception return address not stored");

  a_exc_target: assert property (@(posedge clock) disable iff (!rst_n)
    exc_take |=> redirect.abort && redirect.target[0]
      && redirect.target[63:15] == $past(privileged_vector_base[63:15]))
    else $error("exception target base or mode bit wrong");

  a_data_miss_off: assert property (@(posedge clock) disable iff (!rst_n)
    exc_take && exc_cause == vector_pkg::CAUSE_DATA_MISS |=> redirect.target[14:0] == 15'h0301)
    else $error("data miss offset wrong");

  a_gated_opcode: assert property (@(posedge clock) disable iff (!rst_n)
    issue_chk.valid && issue_chk.opcode == 6'h19 && !hwe_q && !exc_req.valid
      |=> redirect.target[14:0] == 15'h0401)
    else $error("gated opcode not diverted");

  a_fcw_first_latch: assert property (@(posedge clock) disable iff (!rst_n)
    fcw_issue.valid |=> fcr_first == $past(fcw_issue.data))
    else $error("float-control first latch not loaded");

  a_fcw_trap: assert property (@(posedge clock) disable iff (!rst_n)
    s_fcw_trap_due |=> redirect.abort && redirect.target[14:0] == 15'h0701)
    else $error("float-control write trap wrong");

endmodule : privileged_entry_vector_logic

// ---- tb/pipe_model.sv ----
`timescale 1ns/1ps
module pipe_model
(
  input  wire logic              clock,
  output vector_pkg::call_req_t  call_req,
  output vector_pkg::exc_req_t   exc_req,
  output vector_pkg::issue_chk_t issue_chk,
  output vector_pkg::fcw_issue_t fcw_issue,
  output logic                   fcw_retire,
  output logic [1:0]             current_mode_field,
  output logic                   privileged_code_mode
);
  initial {call_req, exc_req, issue_chk, fcw_issue, fcw_retire, current_mode_field,
           privileged_code_mode} = '0;
  // One-cycle request, then idle payload scrambled
  task automatic fire(input int k, input logic [7:0] f, input logic [63:0] d);
    @(posedge clock);
    case (k)
      0: call_req <= '{1'b1, f, d};
      1: exc_req <= '{1'b1, vector_pkg::cause_t'(f[3:0]), d};
      2: issue_chk <= '{1'b1, f[5:0], f[6], f[7], d};
      3: fcw_issue <= '{1'b1, ~d, d};
      default: fcw_retire <= 1'b1;
    endcase
    @(posedge clock);
    call_req <= {1'b0, ~call_req[71:0]};
    exc_req <= {1'b0, exc_req[67:64], ~exc_req[63:0]};
    issue_chk <= {1'b0, ~issue_chk[71:0]};
    fcw_issue <= {1'b0, ~fcw_issue[127:0]};
    fcw_retire <= 1'b0;
  endtask : fire
  task automatic set_mode(input logic [1:0] m, input logic p);
    @(posedge clock);
    current_mode_field <= m;
    privileged_code_mode <= p;
  endtask : set_mode
endmodule : pipe_model

// ---- tb/privileged_entry_vector_logic_tb_top.sv ----
`timescale 1ns/1ps
module privileged_entry_vector_logic_tb_top;
  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata, rd;
  logic                   pready, pslverr, er, fetch_idle, fcw_retire, privileged_code_mode;
  logic [1:0]             current_mode_field;
  vector_pkg::call_req_t  call_req;
  vector_pkg::exc_req_t   exc_req;
  vector_pkg::issue_chk_t issue_chk;
  vector_pkg::fcw_issue_t fcw_issue;
  vector_pkg::redirect_t  redirect;
  vector_pkg::word_push_t link_write, ras_push;
  logic [63:0]            exc_return_addr, fcr_first, fcr_second;
  logic [63:0]            base = 64'h12345678ABCD8000;
  logic [63:0]            ill = 64'h12345678ABCD8401;
  logic [14:0]            offs [15] = '{15'h0, 15'h100, 15'h180, 15'h200, 15'h280, 15'h300,
    15'h380, 15'h400, 15'h480, 15'h500, 15'h580, 15'h600, 15'h680, 15'h700, 15'h780};
  int                     error_cnt = 0;
  int                     comparisons = 0;
  always #2.5 clock = ~clock;
  privileged_entry_vector_logic u_privileged_entry_vector_logic
  (
    .clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .call_req, .exc_req, .issue_chk, .fcw_issue, .fcw_retire,
    .current_mode_field, .privileged_code_mode, .fetch_idle, .redirect, .link_write,
    .ras_push, .exc_return_addr, .fcr_first, .fcr_second
  );
  pipe_model u_pipe_model
  (
    .clock, .call_req, .exc_req, .issue_chk, .fcw_issue, .fcw_retire,
    .current_mode_field, .privileged_code_mode
  );
  function automatic logic [63:0] pcv(input int k, input logic [7:0] f);
    return {48'hC0DE0000F000, k[7:0], f};
  endfunction : pcv
  function automatic logic [63:0] tgt(input logic [7:0] f);
    return {base[63:15], 2'h1, f[7], f[5:0], 6'h01};
  endfunction : tgt
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic do_call(input logic [7:0] f, input logic [63:0] t);
    u_pipe_model.fire(0, f, 64'h1235);
    #1;
    chk({fetch_idle, link_write.valid, ras_push.valid}, 3'h7);
    chk(link_write.data, {63'h91A, privileged_code_mode});
    chk(ras_push.data, 64'h1235);
    @(posedge clock);
    #1;
    chk({redirect.valid, fetch_idle}, 2'h2);
    chk(redirect.target, t);
  endtask : do_call
  task automatic do_exc(input int k, input logic [7:0] f, input logic [14:0] off);
    u_pipe_model.fire(k, f, pcv(k, f));
    #1;
    if (k == 3)
    begin
      chk(fcr_first, ~pcv(k, f));
      @(posedge clock);
      #1;
    end
    chk({redirect.valid, redirect.abort, ras_push.valid}, 3'h7);
    chk(redirect.target, {base[63:15], off[14:1], 1'b1});
    chk(exc_return_addr, pcv(k, f));
    chk(ras_push.data, pcv(k, f));
  endtask : do_exc
  task automatic finish_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b1, vector_pkg::REG_BASE_LO, 32'hABCDFFFF);
    apb(1'b1, vector_pkg::REG_BASE_HI, 32'h12345678);
    apb(1'b0, vector_pkg::REG_BASE_LO, 32'h0);
    chk({er, rd}, 33'h0ABCD8000);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 33'h100000000);
    $display("test registers done");
    do_call(8'h05, tgt(8'h05));
    chk(redirect.abort, 1'b0);
    u_pipe_model.set_mode(2'h3, 1'b1);
    do_call(8'hBF, tgt(8'hBF));
    do_call(8'h40, ill);
    do_call(8'h7F, ill);
    do_call(8'hC0, ill);
    do_call(8'h3F, ill);
    u_pipe_model.set_mode(2'h0, 1'b0);
    do_call(8'h3F, tgt(8'h3F));
    $display("test calls done");
    for (int c = 1; c < 15; c++) do_exc(1, 8'(c), offs[c]);
    u_pipe_model.set_mode(2'h3, 1'b0);
    do_exc(2, 8'h01, 15'h400);
    do_exc(2, 8'h07, 15'h400);
    do_exc(2, 8'h19, 15'h400);
    do_exc(2, 8'h40, 15'h400);
    do_exc(2, 8'h80, 15'h400);
    apb(1'b1, vector_pkg::REG_CTRL, 32'h1);
    apb(1'b0, vector_pkg::REG_CTRL, 32'h0);
    chk({er, rd}, 33'h000000001);
    u_pipe_model.set_mode(2'h3, 1'b1);
    u_pipe_model.fire(2, 8'h19, 64'h0);
    #1;
    chk(redirect.valid, 1'b0);
    chk(fcr_second, 64'h0);
    do_exc(3, 8'h00, 15'h700);
    u_pipe_model.fire(4, 8'h00, 64'h0);
    #1;
    chk(fcr_second, ~pcv(3, 8'h00));
    apb(1'b0, vector_pkg::REG_STATUS, 32'h0);
    chk({er, rd}, 33'h0000000D0);
    apb(1'b0, vector_pkg::REG_EXC_LO, 32'h0);
    chk({er, rd}, 33'h0F0000300);
    apb(1'b0, vector_pkg::REG_FCR_LO, 32'h0);
    chk({er, rd}, 33'h00FFFFCFF);
    $display("test exceptions done");
    finish_test();
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    error_cnt++;
    finish_test();
  end
endmodule : privileged_entry_vector_logic_tb_top
